// [hw/ebp_pkg.sv]
package ebp_pkg;
  // Timing
  localparam int TOSC_NS = 10;
  localparam int INSTR_NS = 40;
  localparam int INSTR_CYC = (INSTR_NS + TOSC_NS - 1) / TOSC_NS;
  // Register byte offsets
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_ENABLES = 8'h04;
  localparam logic [7:0] ADDR_DUTY_LOW = 8'h08;
  localparam logic [7:0] ADDR_SHADOW = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_DEADBAND = 8'h14;
  localparam logic [7:0] ADDR_PERIOD = 8'h18;
  localparam logic [7:0] ADDR_TBCOUNT = 8'h1c;
  localparam logic [7:0] ADDR_TBCTL = 8'h20;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DEADBAND_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] TBCOUNT_RST = 8'h00;
  localparam logic [6:0] TBCTL_RST = 7'h00;
  // Field positions
  localparam int FLAG_TB = 1;
  localparam int CTL_POL_BD = 0;
  localparam int CTL_POL_AC = 1;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_DLSB_LSB = 4;
  localparam int CTL_CFG_LSB = 6;
  localparam int TB_PS_LSB = 0;
  localparam int TB_ON = 2;
  localparam int TB_POST_LSB = 3;
  localparam logic [1:0] MODE_PWM = 2'h3;
  // Prescaler terminal counts per select 00, 01, 1x
  localparam logic [5:0] PRE_LAST_1 = 6'h03;
  localparam logic [5:0] PRE_LAST_4 = 6'h0f;
  localparam logic [5:0] PRE_LAST_16 = 6'h3f;

  typedef enum logic [1:0] {
    CFG_SINGLE = 2'h0,
    CFG_FB_FWD = 2'h1,
    CFG_HALF = 2'h2,
    CFG_FB_REV = 2'h3
  } ebp_cfg_e;

  typedef enum logic [1:0] {
    AS_IDLE = 2'h0,
    AS_WAIT = 2'h1,
    AS_DONE = 2'h3
  } ebp_ahb_e;
endpackage

// [hw/ebp_reg_if.sv]
`timescale 1ns/10ps
interface ebp_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  modport bus (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport core (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// [hw/ebp_ahb_slave.sv]
`timescale 1ns/10ps
module ebp_ahb_slave (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register side
  ebp_reg_if.bus rif
);
  typedef struct packed {
    ebp_pkg::ebp_ahb_e st;
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
  } ebp_ahb_s;

  ebp_ahb_s s;
  ebp_ahb_s next_s;
  logic take;

  assign take = hsel && htrans[1] && hready;
  // Reads stall one cycle so a write just ahead is already visible
  assign hreadyout = (s.st != ebp_pkg::AS_WAIT);
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign rif.rd_addr = s.addr;
  assign rif.wr_en = (s.st == ebp_pkg::AS_DONE) && s.wr && (hsize == hsize);
  assign rif.wr_addr = s.addr;
  assign rif.wr_data = hwdata[7:0];

  always_comb
  begin
    next_s = s;
    case (s.st)
      ebp_pkg::AS_WAIT:
      begin
        next_s.rdata = {24'h000000, rif.rd_data};
        next_s.st = ebp_pkg::AS_DONE;
        next_s.wr = 1'b0;
      end
      ebp_pkg::AS_IDLE, ebp_pkg::AS_DONE:
      begin
        next_s.wr = 1'b0;
        next_s.st = ebp_pkg::AS_IDLE;
        if (take)
        begin
          next_s.addr = {haddr[7:2], 2'h0};
          next_s.wr = hwrite;
          next_s.st = hwrite ? ebp_pkg::AS_DONE : ebp_pkg::AS_WAIT;
        end
      end
      default: next_s.st = ebp_pkg::AS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '{st: ebp_pkg::AS_IDLE, wr: 1'b0, addr: 8'h00, rdata: 32'h00000000};
    else
      s <= next_s;
  end
endmodule

// [hw/ebp_deadband.sv]
`timescale 1ns/10ps
module ebp_deadband (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic tick,
  input wire logic [7:0] delay,
  // Levels, 1 means active
  input wire logic raw,
  output logic act
);
  typedef struct packed {
    logic [7:0] cnt;
    logic act;
  } ebp_db_s;

  ebp_db_s s;
  ebp_db_s next_s;

  assign act = s.act;

  always_comb
  begin
    next_s = s;
    if (!raw)
    begin
      // Turn-off is never delayed
      next_s.act = 1'b0;
      next_s.cnt = 8'h00;
    end
    else if (!s.act)
    begin
      if (s.cnt >= delay)
        next_s.act = 1'b1;
      else if (tick)
        next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '{cnt: 8'h00, act: 1'b0};
    else
      s <= next_s;
  end
endmodule

// [hw/ebp_top.sv]
// Overview of operation
// - Period is (period limit plus one) times four clocks times prescale.
// - After count meets limit: clear count, set output unless zero duty, load shadow.
// - Postscaler only paces the period flag, never the PWM frequency.
// - Duty is 10 bits: duty low register high bits, control bits 5:4 low.
// - High time is duty times one clock times prescale.
// - Duty writes anytime; they take effect only at period end.
// - In PWM mode the shadow register is read-only.
// - Duty double-buffered in shadow plus hidden 2-bit latch, glitch free.
// - Output clears when shadow and latch match count plus two phase bits.
// - Duty beyond period never clears output; full duty results.
// - Output configuration field selects single, half, forward or reverse bridge.
// - Single mode drives output A only; outside party enables the pin driver.
// - Half-bridge drives PWM on A and its complement on B.
// - Half-bridge delays only inactive-to-active edges by the deadband count.
// - Low two mode bits choose active high or low: bit 1 for A and C, bit 0 for B and D.
// - Forward: A steady, D modulated; reverse: C steady, B modulated.
// - Full bridge uses four outputs, only two ever active.
// - Deadband count is in instruction cycles of four clocks.
// - Direction change adopted next period; steady outputs switch early, modulated go inactive.
// - Full bridge applies no deadband.
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
module ebp_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Bridge outputs
  output logic out_a,
  output logic out_b,
  output logic out_c,
  output logic out_d
);
  typedef struct packed {
    logic tb_flag;
    logic [7:0] enables;
    logic [7:0] duty_low;
    logic [7:0] shadow;
    logic [1:0] latch2;
    logic [7:0] ctrl;
    logic [7:0] dband;
    logic [7:0] period;
    logic [7:0] tmr;
    logic [6:0] tbctl;
    logic [5:0] pre;
    logic [3:0] post;
    logic [1:0] icyc;
    logic pwm;
    logic dir;
    logic [3:0] pins;
  } ebp_top_s;

  ebp_top_s s;
  ebp_top_s next_s;
  ebp_reg_if rif ();

  logic run;
  logic pwm_on;
  logic [1:0] ps;
  logic [5:0] pre_last;
  logic tick_last;
  logic [1:0] phase;
  logic fine_zero;
  logic period_end;
  logic match;
  logic pwm_live;
  logic early;
  logic icyc_tick;
  ebp_pkg::ebp_cfg_e cfg;
  logic [9:0] duty_buf;
  logic half;
  logic db_a;
  logic db_b;
  logic [3:0] act;
  logic [3:0] pol;
  logic wr_shadow;

  ebp_ahb_slave u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rif(rif.bus)
  );

  assign run = s.tbctl[ebp_pkg::TB_ON];
  assign ps = s.tbctl[ebp_pkg::TB_PS_LSB +: 2];
  assign pwm_on = (s.ctrl[ebp_pkg::CTL_MODE_LSB +: 2] == ebp_pkg::MODE_PWM);
  assign cfg = ebp_pkg::ebp_cfg_e'(s.ctrl[ebp_pkg::CTL_CFG_LSB +: 2]);
  assign half = pwm_on && (cfg == ebp_pkg::CFG_HALF);
  assign duty_buf = {s.duty_low, s.ctrl[ebp_pkg::CTL_DLSB_LSB +: 2]};
  assign icyc_tick = (s.icyc == 2'(ebp_pkg::INSTR_CYC - 1));
  assign wr_shadow = rif.wr_en && (rif.wr_addr == ebp_pkg::ADDR_SHADOW);

  // Prescale 1, 4 or 16; the two bits above the fine part are the phase
  always_comb
  begin
    case (ps)
      2'h0:
      begin
        pre_last = ebp_pkg::PRE_LAST_1;
        phase = s.pre[1:0];
        fine_zero = 1'b1;
      end
      2'h1:
      begin
        pre_last = ebp_pkg::PRE_LAST_4;
        phase = s.pre[3:2];
        fine_zero = (s.pre[1:0] == 2'h0);
      end
      default:
      begin
        pre_last = ebp_pkg::PRE_LAST_16;
        phase = s.pre[5:4];
        fine_zero = (s.pre[3:0] == 4'h0);
      end
    endcase
  end

  assign tick_last = run && (s.pre == pre_last);
  assign period_end = tick_last && (s.tmr == s.period);
  // Unreachable duty never matches, so the output stays set
  assign match = run && pwm_on && fine_zero && ({s.tmr, phase} == {s.shadow, s.latch2});
  // Drop the match cycle itself, else high time runs one clock past duty
  assign pwm_live = s.pwm && !match;
  // Last phase quarter of a period is 1, 4 or 16 clocks early
  assign early = pwm_on && cfg[0] && run && (cfg[1] != s.dir) && (s.tmr == s.period)
    && (phase == 2'h3);

  ebp_deadband u_db_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(icyc_tick),
    .delay(s.dband),
    .raw(half && pwm_live),
    .act(db_a)
  );

  ebp_deadband u_db_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(icyc_tick),
    .delay(s.dband),
    .raw(half && !pwm_live),
    .act(db_b)
  );

  // Active levels, bit 0 is output A
  always_comb
  begin
    act = 4'h0;
    if (pwm_on)
    begin
      case (cfg)
        ebp_pkg::CFG_SINGLE: act = {3'h0, pwm_live};
        ebp_pkg::CFG_HALF: act = {2'h0, db_b, db_a};
        default:
        begin
          // No deadband on the bridge paths
          if (early ? cfg[1] : s.dir)
            act = {1'b0, 1'b1, pwm_live && !early, 1'b0};
          else
            act = {pwm_live && !early, 1'b0, 1'b0, 1'b1};
        end
      endcase
    end
  end

  assign pol = {s.ctrl[ebp_pkg::CTL_POL_BD], s.ctrl[ebp_pkg::CTL_POL_AC],
    s.ctrl[ebp_pkg::CTL_POL_BD], s.ctrl[ebp_pkg::CTL_POL_AC]};

  always_comb
  begin
    case (rif.rd_addr)
      ebp_pkg::ADDR_FLAGS: rif.rd_data = 8'(s.tb_flag) << ebp_pkg::FLAG_TB;
      ebp_pkg::ADDR_ENABLES: rif.rd_data = s.enables;
      ebp_pkg::ADDR_DUTY_LOW: rif.rd_data = s.duty_low;
      ebp_pkg::ADDR_SHADOW: rif.rd_data = s.shadow;
      ebp_pkg::ADDR_CONTROL: rif.rd_data = s.ctrl;
      ebp_pkg::ADDR_DEADBAND: rif.rd_data = s.dband;
      ebp_pkg::ADDR_PERIOD: rif.rd_data = s.period;
      ebp_pkg::ADDR_TBCOUNT: rif.rd_data = s.tmr;
      ebp_pkg::ADDR_TBCTL: rif.rd_data = {1'b0, s.tbctl};
      default: rif.rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    next_s = s;
    // Register writes
    if (rif.wr_en)
    begin
      case (rif.wr_addr)
        ebp_pkg::ADDR_FLAGS:
          if (!rif.wr_data[ebp_pkg::FLAG_TB])
            next_s.tb_flag = 1'b0;
        ebp_pkg::ADDR_ENABLES: next_s.enables = rif.wr_data;
        ebp_pkg::ADDR_DUTY_LOW: next_s.duty_low = rif.wr_data;
        ebp_pkg::ADDR_SHADOW:
          if (!pwm_on)
            next_s.shadow = rif.wr_data;
        ebp_pkg::ADDR_CONTROL: next_s.ctrl = rif.wr_data;
        ebp_pkg::ADDR_DEADBAND: next_s.dband = rif.wr_data;
        ebp_pkg::ADDR_PERIOD: next_s.period = rif.wr_data;
        ebp_pkg::ADDR_TBCOUNT: next_s.tmr = rif.wr_data;
        ebp_pkg::ADDR_TBCTL: next_s.tbctl = rif.wr_data[6:0];
        default: next_s.tbctl = s.tbctl;
      endcase
    end
    next_s.icyc = s.icyc + 2'h1;
    // Timebase
    if (run)
      next_s.pre = tick_last ? 6'h00 : s.pre + 6'h01;
    if (tick_last)
      next_s.tmr = period_end ? 8'h00 : s.tmr + 8'h01;
    // Output latch and double buffer
    if (period_end)
    begin
      next_s.shadow = s.duty_low;
      next_s.latch2 = s.ctrl[ebp_pkg::CTL_DLSB_LSB +: 2];
      next_s.pwm = pwm_on && (duty_buf != 10'h000);
      next_s.dir = cfg[1];
      // Postscaler paces only the flag
      if (s.post == s.tbctl[ebp_pkg::TB_POST_LSB +: 4])
      begin
        next_s.post = 4'h0;
        next_s.tb_flag = 1'b1;
      end
      else
        next_s.post = s.post + 4'h1;
    end
    else if (match || !pwm_on)
      next_s.pwm = 1'b0;
    if (!(pwm_on && cfg[0]))
      next_s.dir = cfg[1];
    next_s.pins = act ^ pol;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '{tb_flag: 1'b0, enables: ebp_pkg::ENABLES_RST, duty_low: ebp_pkg::DUTY_RST,
        shadow: ebp_pkg::DUTY_RST, latch2: 2'h0, ctrl: ebp_pkg::CONTROL_RST,
        dband: ebp_pkg::DEADBAND_RST, period: ebp_pkg::PERIOD_RST,
        tmr: ebp_pkg::TBCOUNT_RST, tbctl: ebp_pkg::TBCTL_RST, pre: 6'h00, post: 4'h0,
        icyc: 2'h0, pwm: 1'b0, dir: 1'b0, pins: 4'h0};
    else
      s <= next_s;
  end

  assign out_a = s.pins[0];
  assign out_b = s.pins[1];
  assign out_c = s.pins[2];
  assign out_d = s.pins[3];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_period_clear: assert property (period_end |=> s.tmr == 8'h00)
    else $error("count not cleared after period end");
  chk_shadow_load: assert property (period_end |=> s.shadow == $past(s.duty_low)
    && s.latch2 == $past(s.ctrl[5:4]))
    else $error("shadow not loaded at period end");
  chk_zero_duty: assert property (period_end && duty_buf == 10'h000 |=> !s.pwm)
    else $error("output set with zero duty");
  chk_set_output: assert property (period_end && pwm_on && duty_buf != 10'h000 |=> s.pwm)
    else $error("output not set at period start");
  chk_shadow_ro: assert property (pwm_on && wr_shadow && !period_end |=> $stable(s.shadow))
    else $error("shadow written in pwm mode");
  chk_match_clear: assert property (match && !period_end |=> !s.pwm)
    else $error("output not cleared on match");
  // Prescale change leaves the counter above its new wrap for a while; skip that stretch
  chk_prescale_span: assert property ((run && ps == 2'h0 && s.pre <= 6'h03) [*5]
    ##0 tick_last |-> $past(tick_last, 4))
    else $error("timebase tick not every four clocks");
  chk_single_out: assert property (pwm_on && cfg == ebp_pkg::CFG_SINGLE
    |=> s.pins[3:1] == $past(pol[3:1]))
    else $error("single mode drives extra outputs");
  chk_half_overlap: assert property (half |-> !(db_a && db_b))
    else $error("half bridge outputs both active");
  chk_fb_two: assert property (pwm_on && cfg[0] |-> $countones(act) <= 2
    && !(act[1] && act[3]) && !(act[0] && act[2]))
    else $error("full bridge active count wrong");
  chk_early_mod: assert property (early |-> !act[1] && !act[3])
    else $error("modulated output active during turnaround");

  cov_period: cover property (period_end && pwm_on && duty_buf != 10'h000);
  cov_match: cover property (match && s.pwm);
  cov_half_db: cover property (half && !db_a ##1 db_a);
  cov_turn: cover property (early ##1 period_end);
endmodule

// [verif/ebp_switch_model.sv]
`timescale 1ns/10ps
module ebp_switch_model (
  // Clock
  input wire logic hclk,
  // Bridge pins, order a b c d
  input wire logic [3:0] pins,
  input wire logic [1:0] pol,
  input wire logic drv_n,
  // Status
  output int shoot
);
  logic [3:0] on;
  // Polarity is set only with drivers off, never changed live
  assign on = pins ^ {pol[1], pol[0], pol[1], pol[0]};
  initial shoot = 0;
  // Switches follow pins only once direction bits are cleared
  // Both switches of one leg on means shoot-through
  always @(posedge hclk)
    if (!drv_n && ((on[3] && on[2]) || (on[1] && on[0])))
      shoot <= shoot + 1;
endmodule

// [verif/tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("mismatch %0t got %h exp %h", $time, a, b); \
    end \
  end
module tb_top;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic out_a, out_b, out_c, out_d;
  logic drv_n = 1;
  logic [1:0] pol = '0;
  int shoot;
  int miscompares = 0;
  int cmp_count = 0;
  int hi, hb, per;
  logic [7:0] q;

  always #5 hclk = ~hclk;

  ebp_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d)
  );

  ebp_switch_model sw (
    .hclk(hclk), .pins({out_a, out_b, out_c, out_d}), .pol(pol), .drv_n(drv_n),
    .shoot(shoot)
  );

  task print_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Ready seen at negedge is what the next rising edge samples
  task wrdy;
    bit r;
    int n;
    n = 0;
    r = 0;
    while (!r)
    begin
      @(negedge hclk);
      r = (hreadyout === 1'b1);
      @(posedge hclk);
      if (++n > 100)
      begin
        miscompares++;
        print_verdict;
      end
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wrdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wrdy;
    q = hrdata[7:0];
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    `CHK(q, e)
  endtask

  task idle(input int n);
    repeat (n) @(negedge hclk);
  endtask

  // One out_a period from rising edge to rising edge
  task meas;
    int n;
    logic p;
    n = 0;
    p = 1;
    while (!(p === 1'b0 && out_a === 1'b1))
    begin
      p = out_a;
      @(negedge hclk);
      if (++n > 3000)
      begin
        miscompares++;
        print_verdict;
      end
    end
    hi = 0;
    hb = 0;
    per = 0;
    do
    begin
      hi += out_a;
      hb += out_b;
      per++;
      p = out_a;
      @(negedge hclk);
    end
    while (!(p === 1'b0 && out_a === 1'b1) && per < 3000);
  endtask

  // Pins over a window: steady bits exact, masked bit must modulate
  task win(input logic [7:0] c, input logic [3:0] st, input logic [3:0] mk);
    int m;
    logic [3:0] v;
    m = 0;
    bus(1, ebp_pkg::ADDR_CONTROL, c);
    idle(80);
    repeat (40)
    begin
      v = {out_a, out_b, out_c, out_d};
      `CHK(v & ~mk, st)
      m += (|(v & mk));
      @(negedge hclk);
    end
    `CHK(mk == 4'h0 || (m > 0 && m < 40), 1'b1)
  endtask

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    // Reset values and an unmapped word
    rd(ebp_pkg::ADDR_FLAGS, ebp_pkg::FLAGS_RST);
    rd(ebp_pkg::ADDR_ENABLES, ebp_pkg::ENABLES_RST);
    rd(ebp_pkg::ADDR_CONTROL, ebp_pkg::CONTROL_RST);
    rd(ebp_pkg::ADDR_DEADBAND, ebp_pkg::DEADBAND_RST);
    rd(ebp_pkg::ADDR_PERIOD, ebp_pkg::PERIOD_RST);
    rd(ebp_pkg::ADDR_TBCOUNT, ebp_pkg::TBCOUNT_RST);
    rd(ebp_pkg::ADDR_TBCTL, {1'b0, ebp_pkg::TBCTL_RST});
    rd(8'h40, 8'h00);
    `CHK(hresp, 1'b0)
    bus(1, ebp_pkg::ADDR_ENABLES, 8'ha5);
    rd(ebp_pkg::ADDR_ENABLES, 8'ha5);
    // Shadow writable off PWM mode, read-only in it
    bus(1, ebp_pkg::ADDR_SHADOW, 8'h5a);
    rd(ebp_pkg::ADDR_SHADOW, 8'h5a);
    bus(1, ebp_pkg::ADDR_CONTROL, 8'h0c);
    bus(1, ebp_pkg::ADDR_SHADOW, 8'h33);
    rd(ebp_pkg::ADDR_SHADOW, 8'h5a);
    // Single output, limit 3, duty 1:3 = 7, prescale 1
    bus(1, ebp_pkg::ADDR_PERIOD, 8'h03);
    bus(1, ebp_pkg::ADDR_DUTY_LOW, 8'h01);
    bus(1, ebp_pkg::ADDR_CONTROL, 8'h3c);
    bus(1, ebp_pkg::ADDR_TBCTL, 8'h04);
    meas;
    meas;
    `CHK(per, 16)
    `CHK(hi, 7)
    `CHK(hb, 0)
    rd(ebp_pkg::ADDR_SHADOW, 8'h01);
    // New duty lands at the period end
    bus(1, ebp_pkg::ADDR_DUTY_LOW, 8'h02);
    bus(1, ebp_pkg::ADDR_CONTROL, 8'h0c);
    meas;
    meas;
    `CHK(hi, 8)
    // Prescale 4 stretches period and duty; postscale leaves period
    bus(1, ebp_pkg::ADDR_TBCTL, 8'h0d);
    meas;
    meas;
    `CHK(per, 64)
    `CHK(hi, 32)
    bus(1, ebp_pkg::ADDR_FLAGS, 8'h00);
    idle(140);
    rd(ebp_pkg::ADDR_FLAGS, 8'h02);
    bus(1, ebp_pkg::ADDR_TBCTL, 8'h04);
    // Duty 0 never sets, duty past period never clears
    bus(1, ebp_pkg::ADDR_DUTY_LOW, 8'h00);
    pol = 2'h2;
    win(8'h0e, 4'ha, 4'h0);
    pol = 2'h0;
    bus(1, ebp_pkg::ADDR_DUTY_LOW, 8'hff);
    win(8'h0c, 4'h8, 4'h0);
    // Half bridge with deadband, drivers enabled after a full period
    bus(1, ebp_pkg::ADDR_DUTY_LOW, 8'h02);
    bus(1, ebp_pkg::ADDR_DEADBAND, 8'h01);
    bus(1, ebp_pkg::ADDR_CONTROL, 8'h8c);
    idle(40);
    drv_n = 0;
    meas;
    meas;
    `CHK(per, 16)
    `CHK(hb > 0 && hi + hb < 16, 1'b1)
    // Full bridge forward then reverse, no deadband
    bus(1, ebp_pkg::ADDR_DUTY_LOW, 8'h01);
    win(8'h4c, 4'h8, 4'h1);
    win(8'hcc, 4'h2, 4'h4);
    `CHK(shoot, 0)
    print_verdict;
  end
endmodule
